// File: rtl/tmz_params.svh
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TMZ_PARAMS_SVH
`define TMZ_PARAMS_SVH
`define TMZ_ADDR_W 8
`define TMZ_OFS_ICTL_A 8'h0B
`define TMZ_OFS_ICTL_B 8'h8B
`define TMZ_OFS_PFLG 8'h0C
`define TMZ_OFS_PEN 8'h8C
`define TMZ_OFS_COUNT 8'h01
`define TMZ_OFS_OPTION 8'h81
`define TMZ_BIT_GIE 7
`define TMZ_BIT_PEIE 6
`define TMZ_BIT_TIMER_OVERFLOW_IRQ_ENABLE 5
`define TMZ_BIT_EXTE 4
`define TMZ_BIT_PCIE 3
`define TMZ_BIT_TIMER_OVERFLOW_FLAG 2
`define TMZ_BIT_EXTF 1
`define TMZ_BIT_PCF 0
`define TMZ_BIT_CMP 6
`define TMZ_BIT_CSS 5
`define TMZ_BIT_CES 4
`define TMZ_BIT_PSA 3
`define TMZ_RST_ICTL 8'h00
`define TMZ_RST_PEN 8'h00
`define TMZ_RST_PFLG 8'h00
`define TMZ_RST_COUNT 8'h00
`define TMZ_RST_OPTION 8'hFF
`define TMZ_OSC_PER_CYCLE 4
`define TMZ_WRITE_HOLD 2
`endif

// File: rtl/tmz_pkg.sv
// Types shared by the timer block
package tmz_pkg;
	typedef enum logic [1:0] {
		TMZ_RUN = 2'b00, // Counting normally
		TMZ_HOLD1 = 2'b01, // First inhibited cycle
		TMZ_HOLD2 = 2'b10 // Second inhibited cycle
	} tmz_hold_t;
endpackage

// File: rtl/tmz_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module tmz_sync #(
	parameter int W = 1 // Number of pins
) (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic [W-1:0] pin_i, // Asynchronous pins
	output logic [W-1:0] level_o // Filtered level
);
	logic [W-1:0] s1_ff; // Metastability stage
	logic [W-1:0] s2_ff; // Second stage
	logic [W-1:0] s3_ff; // Third stage
	wire [W-1:0] nxt_level; // Level to load next

	// Shift chain; first stage feeds only the second
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Each pin keeps its level until the two late stages agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_agree
			assign nxt_level[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : level_o[g];
		end
	endgenerate

	// Filtered level; one process owns the whole output
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			level_o <= '0;
		end else begin
			level_o <= nxt_level;
		end
	end
endmodule // tmz_sync

// File: rtl/tmz_prescaler.sv
// Shared eight-bit prescaler for timer or watchdog
`timescale 1ns/1ns
module tmz_prescaler (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic tick_i, // Source event
	input wire logic clr_i, // Clear internal count
	input wire logic [2:0] rate_i, // Divide by 2 to 256
	output logic tick_o // Divided event pulse
);
	logic [7:0] cnt_ff; // Hidden count, no software path
	logic [7:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff + 8'h01;
	end

	// Count is never exposed; only the output pulse leaves
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || clr_i) begin
			cnt_ff <= 8'h00;
		end else if (tick_i) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Pulse when the selected bit falls: divide by 2^(rate+1)
	always_comb begin
		tick_o = tick_i && cnt_ff[rate_i] && !nxt_cnt[rate_i];
	end
endmodule // tmz_prescaler

// File: rtl/tmz_timer.sv
// Eight-bit cycle timer with interrupt control and flag registers
`timescale 1ns/1ns
`include "tmz_params.svh"
module tmz_timer (
	input wire logic sys_clk_i, // Oscillator clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, high
	input wire logic [7:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, next cycle
	input wire logic sleep_i, // Core is asleep
	input wire logic return_from_irq_i, // Return-from-interrupt pulse
	input wire logic ext_count_pin_i, // External count pin
	input wire logic ext_irq_pin_i, // External interrupt pin
	input wire logic [3:0] port_hi_i, // Port pins 7:4
	input wire logic [1:0] comparator_out_i, // Comparator outputs
	input wire logic wdt_tick_i, // Watchdog source tick
	output logic wdt_tick_o, // Watchdog tick after prescaler
	output logic cycle_o, // Instruction cycle enable
	output logic irq_o // Interrupt request to core
);
	logic [7:0] ictl_ff; // interrupt_control storage
	logic pen_ff; // comparator_irq_enable
	logic pflg_ff; // comparator_irq_flag
	logic [7:0] count_ff; // timer_count
	logic [7:0] option_ff; // Mode and prescaler control
	logic [1:0] phase_ff; // Oscillator phase within a cycle
	tmz_pkg::tmz_hold_t hold_ff; // Write inhibit state
	logic [7:0] rdata_ff; // Registered read data
	logic cpin_d_ff; // Previous synced count pin
	logic epin_d_ff; // Previous synced irq pin
	logic [3:0] port_d_ff; // Previous synced port pins
	logic [1:0] cmp_d_ff; // Previous synced comparator
	logic [7:0] sync_lvl; // Synchronised levels
	logic cpin_edge; // Selected count edge
	logic src_tick; // Raw count source
	logic pre_tick; // Prescaler output
	logic count_tick; // Final increment enable
	logic ovf; // Rollover this cycle
	logic ext_evt; // External interrupt edge
	logic port_evt; // Port change
	logic cmp_evt; // Comparator change
	logic wr_ictl; // Write to control register
	logic [7:0] nxt_ictl;

	// Address decode used by both write and read paths
	function automatic logic is_ictl(input logic [7:0] a);
		return a == `TMZ_OFS_ICTL_A || a == `TMZ_OFS_ICTL_B;
	endfunction

	// Pins cross in through three stages each
	tmz_sync #(.W(8)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.pin_i({comparator_out_i, port_hi_i, ext_irq_pin_i, ext_count_pin_i}),
		.level_o(sync_lvl)
	);

	// Edge memory of synchronised pins
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cpin_d_ff <= 1'b0;
			epin_d_ff <= 1'b0;
			port_d_ff <= 4'h0;
			cmp_d_ff <= 2'h0;
		end else begin
			// Keep the last level of every synchronised pin
			cpin_d_ff <= sync_lvl[0];
			epin_d_ff <= sync_lvl[1];
			port_d_ff <= sync_lvl[5:2];
			cmp_d_ff <= sync_lvl[7:6];
		end
	end

	// Rising edge on the interrupt pin; polarity control lives outside
	assign ext_evt = sync_lvl[1] && !epin_d_ff;
	assign port_evt = sync_lvl[5:2] != port_d_ff;
	assign cmp_evt = sync_lvl[7:6] != cmp_d_ff;
	// Zero selects rising, one selects falling
	assign cpin_edge = option_ff[`TMZ_BIT_CES] ? (cpin_d_ff && !sync_lvl[0]) : (!cpin_d_ff && sync_lvl[0]);

	// Four oscillator periods make one instruction cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			phase_ff <= 2'h0;
		end else begin
			// Free running; register writes never shift the phase
			phase_ff <= phase_ff + 2'h1;
		end
	end
	assign cycle_o = phase_ff == 2'(`TMZ_OSC_PER_CYCLE - 1);
	// Pulse spacing is what every tick count downstream relies on
	a_cycle_period: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		cycle_o |=> !cycle_o [*3] ##1 cycle_o) else $error("cycle pulse spacing wrong");

	// Source mux; sleep freezes the whole timer path
	assign src_tick = sleep_i ? 1'b0 : (option_ff[`TMZ_BIT_CSS] ? cpin_edge : cycle_o);
	// Frozen source means no overflow either, so sleep is never left by it
	a_sleep_no_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sleep_i |-> !ovf) else $error("overflow during sleep");

	// Single prescaler; its input follows the assignment bit
	tmz_prescaler u_pre (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_i(option_ff[`TMZ_BIT_PSA] ? wdt_tick_i : src_tick),
		// Writing the count also clears the hidden prescaler count, but only while the prescaler serves the timer
		.clr_i(wr_i && addr_i == `TMZ_OFS_COUNT && !option_ff[`TMZ_BIT_PSA]),
		.rate_i(option_ff[2:0]),
		.tick_o(pre_tick)
	);
	assign wdt_tick_o = option_ff[`TMZ_BIT_PSA] ? pre_tick : wdt_tick_i;
	assign count_tick = (option_ff[`TMZ_BIT_PSA] ? src_tick : pre_tick) && hold_ff == tmz_pkg::TMZ_RUN;
	assign ovf = count_tick && count_ff == 8'hFF;
	// With the prescaler on the timer the watchdog runs undivided
	a_wdt_bypass: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!option_ff[`TMZ_BIT_PSA] |-> wdt_tick_o == wdt_tick_i) else $error("watchdog tick not passed");
	// A watchdog pulse only ever comes from a watchdog source tick
	a_wdt_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(option_ff[`TMZ_BIT_PSA] && !wdt_tick_i) |-> !wdt_tick_o) else $error("stray watchdog tick");
	// Counter mode never counts without a selected pin edge
	a_pin_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(option_ff[`TMZ_BIT_CSS] && !cpin_edge) |-> !count_tick) else $error("count without pin edge");

	// Inhibit state advances on instruction cycles after a write
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			hold_ff <= tmz_pkg::TMZ_RUN;
		end else if (wr_i && addr_i == `TMZ_OFS_COUNT) begin
			// A fresh write restarts the inhibit
			hold_ff <= tmz_pkg::TMZ_HOLD1;
		end else if (cycle_o) begin
			// One step per instruction cycle; counting resumes after the second
			case (hold_ff)
				tmz_pkg::TMZ_HOLD1: hold_ff <= tmz_pkg::TMZ_HOLD2;
				tmz_pkg::TMZ_HOLD2: hold_ff <= tmz_pkg::TMZ_RUN;
				default: hold_ff <= tmz_pkg::TMZ_RUN;
			endcase
		end
	end

	// Inhibit walks both steps in order, never skipping one
	a_hold_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(hold_ff == tmz_pkg::TMZ_HOLD1 && cycle_o && !wr_i) |=> hold_ff == tmz_pkg::TMZ_HOLD2)
		else $error("inhibit skipped a step");
	a_hold_resume: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(hold_ff == tmz_pkg::TMZ_HOLD2 && cycle_o && !wr_i) |=> hold_ff == tmz_pkg::TMZ_RUN)
		else $error("inhibit did not end");

	// Timer count: write loads, tick increments
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			count_ff <= `TMZ_RST_COUNT;
		end else if (wr_i && addr_i == `TMZ_OFS_COUNT) begin
			// Write beats a tick in the same cycle; that tick is lost
			count_ff <= wdata_i;
		end else if (count_tick) begin
			count_ff <= count_ff + 8'h01;
		end
	end

	// Write data land as written
	a_count_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `TMZ_OFS_COUNT) |=> count_ff == $past(wdata_i)) else $error("count write lost");
	// Rollover lands on zero
	a_ovf_wraps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ovf && !wr_i) |=> count_ff == 8'h00) else $error("rollover not zero");
	// With the prescaler on the watchdog, a selected pin edge moves the count by one
	a_edge_counts: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(option_ff[`TMZ_BIT_CSS] && option_ff[`TMZ_BIT_PSA] && cpin_edge && !sleep_i
		&& hold_ff == tmz_pkg::TMZ_RUN && !wr_i) |=> count_ff == $past(count_ff) + 8'h01)
		else $error("pin edge missed");

	// Option register steering the mode
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			// Reset value hands the prescaler to the watchdog
			option_ff <= `TMZ_RST_OPTION;
		end else if (wr_i && addr_i == `TMZ_OFS_OPTION) begin
			option_ff <= wdata_i;
		end
	end

	// Control register; hardware sets win over software clears
	assign wr_ictl = wr_i && is_ictl(addr_i);
	always_comb begin
		// Software value first; hardware events then override it
		nxt_ictl = wr_ictl ? wdata_i : ictl_ff;
		if (return_from_irq_i) begin
			nxt_ictl[`TMZ_BIT_GIE] = 1'b1;
		end
		if (ovf) begin
			nxt_ictl[`TMZ_BIT_TIMER_OVERFLOW_FLAG] = 1'b1;
		end
		if (ext_evt) begin
			nxt_ictl[`TMZ_BIT_EXTF] = 1'b1;
		end
		if (port_evt) begin
			nxt_ictl[`TMZ_BIT_PCF] = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ictl_ff <= `TMZ_RST_ICTL;
		end else begin
			// Single owner of the control storage behind both aliases
			ictl_ff <= nxt_ictl;
		end
	end

	// Every event reaches its flag, whatever the enables or a clearing write say
	a_ext_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ext_evt |=> ictl_ff[`TMZ_BIT_EXTF]) else $error("pin flag not set");
	a_port_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		port_evt |=> ictl_ff[`TMZ_BIT_PCF]) else $error("port flag not set");
	// Flags only fall by a software write
	a_ext_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ictl_ff[`TMZ_BIT_EXTF] && !wr_ictl) |=> ictl_ff[`TMZ_BIT_EXTF]) else $error("pin flag dropped");
	a_port_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ictl_ff[`TMZ_BIT_PCF] && !wr_ictl) |=> ictl_ff[`TMZ_BIT_PCF]) else $error("port flag dropped");

	// Comparator enable and flag, single bit each
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pen_ff <= 1'b0;
			pflg_ff <= 1'b0;
		end else begin
			// Only bit six is stored; the rest read zero
			if (wr_i && addr_i == `TMZ_OFS_PEN) begin
				pen_ff <= wdata_i[`TMZ_BIT_CMP];
			end
			// A change beats a clearing write in the same cycle
			if (cmp_evt) begin
				pflg_ff <= 1'b1;
			end else if (wr_i && addr_i == `TMZ_OFS_PFLG) begin
				pflg_ff <= wdata_i[`TMZ_BIT_CMP];
			end
		end
	end

	// Comparator flag sets on any output change and holds until written
	a_cmp_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		cmp_evt |=> pflg_ff) else $error("comparator flag not set");
	a_cmp_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(pflg_ff && !(wr_i && addr_i == `TMZ_OFS_PFLG)) |=> pflg_ff)
		else $error("comparator flag dropped");

	// Request combines flag, enable, group and global enable
	always_comb begin
		irq_o = ictl_ff[`TMZ_BIT_GIE] && (
			(ictl_ff[`TMZ_BIT_TIMER_OVERFLOW_IRQ_ENABLE] && ictl_ff[`TMZ_BIT_TIMER_OVERFLOW_FLAG]) ||
			(ictl_ff[`TMZ_BIT_EXTE] && ictl_ff[`TMZ_BIT_EXTF]) ||
			(ictl_ff[`TMZ_BIT_PCIE] && ictl_ff[`TMZ_BIT_PCF]) ||
			// Peripheral group needs its own group enable as well
			(ictl_ff[`TMZ_BIT_PEIE] && pen_ff && pflg_ff));
	end

	// No source enabled means no request, whatever the flags
	a_src_masked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(ictl_ff[`TMZ_BIT_TIMER_OVERFLOW_IRQ_ENABLE] || ictl_ff[`TMZ_BIT_EXTE] || ictl_ff[`TMZ_BIT_PCIE] || ictl_ff[`TMZ_BIT_PEIE])
		|-> !irq_o) else $error("request with all sources masked");
	// A write through the high alias lands in the one storage
	a_alias_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `TMZ_OFS_ICTL_B && !return_from_irq_i && !ovf && !ext_evt && !port_evt)
		|=> ictl_ff == $past(wdata_i)) else $error("alias write lost");

	// Read mux; unmapped addresses return zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_i) begin
			// Both control aliases decode to one storage
			if (is_ictl(addr_i)) begin
				rdata_ff <= ictl_ff;
			end else if (addr_i == `TMZ_OFS_COUNT) begin
				rdata_ff <= count_ff;
			end else if (addr_i == `TMZ_OFS_OPTION) begin
				rdata_ff <= option_ff;
			end else if (addr_i == `TMZ_OFS_PEN) begin
				rdata_ff <= {1'b0, pen_ff, 6'h00};
			end else if (addr_i == `TMZ_OFS_PFLG) begin
				rdata_ff <= {1'b0, pflg_ff, 6'h00};
			end else begin
				rdata_ff <= 8'h00;
			end
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	assign rdata_o = rdata_ff;

	// Enable register read shows only bit six
	a_pen_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rd_i && addr_i == `TMZ_OFS_PEN) |=> (rdata_o & 8'hBF) == 8'h00)
		else $error("reserved enable bits set");

	// Overflow must raise the flag on the next edge
	a_ovf_sets_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ovf |=> ictl_ff[`TMZ_BIT_TIMER_OVERFLOW_FLAG]) else $error("overflow did not set flag");
	// No increment in the cycles after a count write
	a_write_inhibit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `TMZ_OFS_COUNT) |=> !count_tick [*4]) else $error("count moved after write");
	// Sleep freezes the count
	a_sleep_freeze: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(sleep_i && !wr_i && $past(sleep_i)) |=> $stable(count_ff)) else $error("timer ran in sleep");
	// No global enable means no request from any source
	a_mask_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!ictl_ff[`TMZ_BIT_GIE] |-> !irq_o) else $error("request without global enable");
	// Return from interrupt sets global enable
	a_reti_gie: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		return_from_irq_i |=> ictl_ff[`TMZ_BIT_GIE]) else $error("global enable not set");
	// Read of the peripheral flag register shows only bit six
	a_pflg_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rd_i && addr_i == `TMZ_OFS_PFLG) |=> (rdata_o & 8'hBF) == 8'h00) else $error("reserved bits set");
	// Both aliases read the same storage
	a_alias_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rd_i && addr_i == `TMZ_OFS_ICTL_B) |=> rdata_o == $past(ictl_ff)) else $error("alias mismatch");
	// Timer mode without prescaler counts once per cycle
	a_timer_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(cycle_o && !sleep_i && !option_ff[`TMZ_BIT_CSS] && option_ff[`TMZ_BIT_PSA]
		&& hold_ff == tmz_pkg::TMZ_RUN && !wr_i) |=> count_ff == $past(count_ff) + 8'h01)
		else $error("timer tick missed");
endmodule // tmz_timer

// File: dv/tmz_pin_model.sv
// Behavioural model of the pins around the timer block
`timescale 1ns/1ns
module tmz_pin_model (
	input wire logic sys_clk_i, // System clock
	output logic ext_count_pin_o, // Count pin
	output logic ext_irq_pin_o, // Interrupt pin
	output logic [3:0] port_hi_o, // Port pins 7:4
	output logic [1:0] comparator_out_o // Comparator outputs
);
	// Quiet pins from time zero
	initial begin
		ext_count_pin_o = 1'b0;
		ext_irq_pin_o = 1'b0;
		port_hi_o = 4'h0;
		comparator_out_o = 2'h0;
	end
	// New pin state, held well past the three-flop filter and one tick
	task automatic drive(input logic c, input logic e, input logic [3:0] p, input logic [1:0] m);
		@(posedge sys_clk_i);
		ext_count_pin_o <= c;
		ext_irq_pin_o <= e;
		port_hi_o <= p;
		comparator_out_o <= m;
		repeat (12) @(posedge sys_clk_i);
	endtask
endmodule // tmz_pin_model

// File: dv/tb_top.sv
// Self-checking testbench of the timer block
`timescale 1ns/1ns
`include "tmz_params.svh"
module tb_top;
	logic sys_clk_i = 1'b0; // Clock
	logic rst_i = 1'b1; // Reset
	logic [7:0] addr_i = 8'h00; // Bus address
	logic [7:0] wdata_i = 8'h00; // Bus data
	logic wr_i = 1'b0; // Write strobe
	logic rd_i = 1'b0; // Read strobe
	logic sleep_i = 1'b0; // Sleep level
	logic rfi = 1'b0; // Return pulse
	logic wdt_tick_i = 1'b0; // Watchdog source
	logic [7:0] rdata_o; // Read data
	logic wdt_tick_o, cycle_o, irq_o; // Outputs
	logic cnt_pin, irq_pin; // Pins
	logic [3:0] port_hi; // Port pins
	logic [1:0] cmp_out; // Comparators
	int n_mismatch = 0; // Mismatches
	int comparisons = 0; // Comparisons
	int cycles = 0; // Timeout count
	int wdt_seen = 0; // Watchdog output pulses
	int k, j; // Loop indices
	logic [7:0] v; // Read value
	// Count rows: option, sleep, accepted count window after 80 clocks
	typedef struct packed {logic [7:0] opt; logic slp; logic [7:0] lo; logic [7:0] hi;} tmz_row_t;
	tmz_row_t rows [5] = '{'{8'h08, 1'b0, 8'h21, 8'h23}, '{8'h00, 1'b0, 8'h18, 8'h1A},
		'{8'h01, 1'b0, 8'h13, 8'h16}, '{8'h07, 1'b0, 8'h10, 8'h10}, '{8'h08, 1'b1, 8'h10, 8'h10}};
	logic [7:0] rst_ofs [7] = '{8'h0B, 8'h8B, 8'h0C, 8'h8C, 8'h01, 8'h81, 8'h55}; // Reset reads
	logic [7:0] rst_exp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00}; // Reset values
	// Clock
	always #5 sys_clk_i = ~sys_clk_i;
	tmz_timer i_tmz_timer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .return_from_irq_i(rfi),
		.ext_count_pin_i(cnt_pin), .ext_irq_pin_i(irq_pin), .port_hi_i(port_hi), .comparator_out_i(cmp_out),
		.wdt_tick_i(wdt_tick_i), .wdt_tick_o(wdt_tick_o), .cycle_o(cycle_o), .irq_o(irq_o));
	tmz_pin_model i_tmz_pin_model (.sys_clk_i(sys_clk_i), .ext_count_pin_o(cnt_pin),
		.ext_irq_pin_o(irq_pin), .port_hi_o(port_hi), .comparator_out_o(cmp_out));
	// Cycle count, watchdog pulse count and hang guard
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (wdt_tick_o === 1'b1) wdt_seen <= wdt_seen + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle read, data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(posedge sys_clk_i);
		d = rdata_o;
	endtask
	// Window compare; an unknown never passes
	task automatic chk(input string s, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
		logic ok;
		ok = (got >= lo) && (got <= hi);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h..%h seen %h", s, lo, hi, got);
		end
	endtask
	// Register read and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a, v);
		chk("register", e, e, v);
	endtask
	// Request level one cycle after the cause
	task automatic irqc(input logic e);
		@(posedge sys_clk_i);
		#1 chk("irq_o", {7'h00, e}, {7'h00, e}, {7'h00, irq_o});
	endtask
	// Verdict
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		// Ordinary count cases, fixed start value
		for (k = 0; k < 5; k++) begin
			wr(`TMZ_OFS_OPTION, rows[k].opt);
			sleep_i <= rows[k].slp;
			wr(`TMZ_OFS_COUNT, 8'h10);
			repeat (80) @(posedge sys_clk_i);
			rd(`TMZ_OFS_COUNT, v);
			chk("timer_count", rows[k].lo, rows[k].hi, v);
			sleep_i <= 1'b0;
		end
		$display("test count rows done");
		// Reset values after a second reset, unmapped place included
		rst_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 7; k++) rc(rst_ofs[k], rst_exp[k]);
		$display("test reset done");
		// Spacing of instruction-cycle pulses
		k = 0;
		while (cycle_o !== 1'b1 && k < 8) begin
			@(posedge sys_clk_i);
			#1 k++;
		end
		k = 0;
		do begin
			@(posedge sys_clk_i);
			#1 k++;
		end while (cycle_o !== 1'b1 && k < 8);
		chk("cycle gap", 8'h04, 8'h04, 8'(k));
		$display("test cycle done");
		// Prescaler on watchdog divides by two, on timer passes watchdog through
		for (j = 0; j < 2; j++) begin
			wr(`TMZ_OFS_OPTION, j ? 8'h00 : 8'h08);
			k = wdt_seen;
			repeat (8) begin
				@(posedge sys_clk_i);
				wdt_tick_i <= 1'b1;
				@(posedge sys_clk_i);
				wdt_tick_i <= 1'b0;
				repeat (2) @(posedge sys_clk_i);
			end
			repeat (4) @(posedge sys_clk_i);
			chk("watchdog ticks", j ? 8'h08 : 8'h04, j ? 8'h08 : 8'h04, 8'(wdt_seen - k));
		end
		$display("test watchdog done");
		// Overflow, masking, clearing and return from interrupt
		wr(`TMZ_OFS_OPTION, 8'h08);
		wr(`TMZ_OFS_ICTL_A, 8'h00);
		wr(`TMZ_OFS_COUNT, 8'hFE);
		repeat (40) @(posedge sys_clk_i);
		rc(`TMZ_OFS_ICTL_A, 8'h04);
		irqc(1'b0);
		wr(`TMZ_OFS_ICTL_B, 8'hA4);
		irqc(1'b1);
		wr(`TMZ_OFS_ICTL_A, 8'hA0);
		rc(`TMZ_OFS_ICTL_B, 8'hA0);
		irqc(1'b0);
		wr(`TMZ_OFS_ICTL_A, 8'h24);
		irqc(1'b0);
		@(posedge sys_clk_i);
		rfi <= 1'b1;
		@(posedge sys_clk_i);
		rfi <= 1'b0;
		rc(`TMZ_OFS_ICTL_A, 8'hA4);
		irqc(1'b1);
		$display("test overflow done");
		// Pin counting, rising then falling edge selected
		wr(`TMZ_OFS_OPTION, 8'h28);
		wr(`TMZ_OFS_COUNT, 8'h00);
		repeat (12) @(posedge sys_clk_i);
		i_tmz_pin_model.drive(1'b1, 1'b0, 4'h0, 2'h0);
		rc(`TMZ_OFS_COUNT, 8'h01);
		i_tmz_pin_model.drive(1'b0, 1'b0, 4'h0, 2'h0);
		rc(`TMZ_OFS_COUNT, 8'h01);
		wr(`TMZ_OFS_OPTION, 8'h38);
		i_tmz_pin_model.drive(1'b1, 1'b0, 4'h0, 2'h0);
		rc(`TMZ_OFS_COUNT, 8'h01);
		i_tmz_pin_model.drive(1'b0, 1'b0, 4'h0, 2'h0);
		rc(`TMZ_OFS_COUNT, 8'h02);
		$display("test counter done");
		// Pin and comparator interrupt sources
		wr(`TMZ_OFS_ICTL_A, 8'h00);
		i_tmz_pin_model.drive(1'b0, 1'b1, 4'h0, 2'h0);
		rc(`TMZ_OFS_ICTL_A, 8'h02);
		wr(`TMZ_OFS_ICTL_A, 8'h92);
		irqc(1'b1);
		wr(`TMZ_OFS_ICTL_A, 8'h82);
		irqc(1'b0);
		wr(`TMZ_OFS_ICTL_A, 8'h00);
		i_tmz_pin_model.drive(1'b0, 1'b1, 4'h8, 2'h0);
		rc(`TMZ_OFS_ICTL_A, 8'h01);
		wr(`TMZ_OFS_ICTL_A, 8'h89);
		irqc(1'b1);
		wr(`TMZ_OFS_ICTL_A, 8'h81);
		irqc(1'b0);
		wr(`TMZ_OFS_ICTL_A, 8'h00);
		wr(`TMZ_OFS_PEN, 8'hFF);
		rc(`TMZ_OFS_PEN, 8'h40);
		i_tmz_pin_model.drive(1'b0, 1'b1, 4'h8, 2'h1);
		rc(`TMZ_OFS_PFLG, 8'h40);
		wr(`TMZ_OFS_ICTL_A, 8'hC0);
		irqc(1'b1);
		wr(`TMZ_OFS_ICTL_A, 8'h80);
		irqc(1'b0);
		wr(8'h55, 8'hFF);
		rc(8'h55, 8'h00);
		$display("test sources done");
		test_done();
	end
endmodule // tb_top
